// >>> design/hold_timer.sv
// Down counter that times the PHY reset hold periods.
// Assumes load is a one-cycle pulse; expired is high whenever the count is zero.
`timescale 1ns/1ps
module hold_timer
	import pm_ctrl_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             load,
	input  wire logic [TMR_W-1:0] load_val,
	output logic                  expired
);
	logic [TMR_W-1:0] count_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (load) begin
			count_r <= load_val;
		end else if (count_r != '0) begin
			count_r <= count_r - 1'b1;
		end
	end

	assign expired = (count_r == '0);

endmodule : hold_timer

// >>> design/phy_reset_wake_status_ctrl.sv
// PHY reset sequencing, device-ready tracking and wake enables and wake cause status.
// Assumes power state, wake events and PHY status inputs are synchronous to core_clk.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
module phy_reset_wake_status_ctrl
	import pm_ctrl_pkg::*;
#(
	parameter int unsigned MIN_HOLD_P = MIN_HOLD_CYC,
	parameter int unsigned REF_MAX_P  = REF_MAX_CYC
) (
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire pm_ctrl_pkg::reg_req_s   reg_req,
	output logic [pm_ctrl_pkg::DATA_W-1:0] reg_rdata,
	input  wire pm_ctrl_pkg::pm_state_e  pm_state,
	input  wire logic                    ext_phy_sel,
	input  wire logic                    config_load_done,
	input  wire logic                    ana_ref_stable,
	input  wire logic                    phy_operational,
	input  wire pm_ctrl_pkg::wake_evt_s  wake_evt,
	input  wire pm_ctrl_pkg::resume_s    resume,
	output logic                         phy_reset_n,
	output logic                         device_ready,
	output logic                         lan_wake_enable,
	output logic                         phy_irq_wake_enable
);
	import pm_ctrl_pkg::*;

	typedef enum logic [2:0] {
		SEQ_OFF  = 3'b000,
		SEQ_HOLD = 3'b001,
		SEQ_REF  = 3'b010,
		SEQ_OPER = 3'b011,
		SEQ_RUN  = 3'b100
	} seq_state_e;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	function automatic logic in_reset(input seq_state_e st);
		in_reset = (st == SEQ_OFF) || (st == SEQ_HOLD) || (st == SEQ_REF);
	endfunction : in_reset

	seq_state_e        seq_r;
	seq_state_e        seq_nxt;
	logic              req_r;
	logic              ready_r;
	logic              cfg_loaded_r;
	logic              phy_reset_request_n_r;
	logic              lan_en_r;
	logic              phy_irq_en_r;
	logic              res_clr_en_r;
	logic              res_clr_sts_r;
	logic              skip_ref_r;
	logic [DATA_W-1:0] rdata_r;
	logic              ctrl_wr;
	logic              cfg_wr;
	logic              req_set;
	logic              int_phy_off;
	logic              release_now;
	logic              tmr_load;
	logic [TMR_W-1:0]  tmr_val;
	logic              tmr_expired;
	logic              remote_resume;
	logic [STS_W-1:0]  sts_set;
	logic [STS_W-1:0]  sts_clr;
	logic [STS_W-1:0]  sts;

	assign ctrl_wr = reg_req.wr && reg_hit(reg_req.addr, PM_CTRL_OFS);
	assign cfg_wr  = reg_req.wr && reg_hit(reg_req.addr, PM_CFG_OFS);

	// A write of one only takes effect while the request is low
	assign req_set = ctrl_wr && reg_req.wdata[PHY_RESET_REQUEST_BIT] && !req_r;

	// Only the internal PHY is powered down by the state machine around it
	assign int_phy_off = !ext_phy_sel && ((pm_state == PM_NORM_UNCFG) || (pm_state == PM_LP2));

	assign release_now = in_reset(seq_r) && !in_reset(seq_nxt) && (seq_nxt != SEQ_OFF);

	// Host resumes leave enables and status alone
	assign remote_resume = resume.done && resume.remote;

	always_comb begin
		seq_nxt  = seq_r;
		tmr_load = 1'b0;
		tmr_val  = TMR_W'(MIN_HOLD_P);
		unique case (seq_r)
			SEQ_OFF: begin
				if (!int_phy_off) begin
					seq_nxt  = SEQ_HOLD;
					tmr_load = 1'b1;
				end
			end
			SEQ_HOLD: begin
				if (int_phy_off) begin
					seq_nxt = SEQ_OFF;
				end else if (tmr_expired) begin
					if (skip_ref_r) begin
						seq_nxt = SEQ_OPER;
					end else begin
						seq_nxt  = SEQ_REF;
						tmr_load = 1'b1;
						tmr_val  = TMR_W'(REF_MAX_P - MIN_HOLD_P);
					end
				end
			end
			SEQ_REF: begin
				// Reference wait ends early once it settles, else at the longest hold
				if (int_phy_off) begin
					seq_nxt = SEQ_OFF;
				end else if (ana_ref_stable || tmr_expired) begin
					seq_nxt = SEQ_OPER;
				end
			end
			SEQ_OPER: begin
				if (int_phy_off) begin
					seq_nxt = SEQ_OFF;
				end else if (req_set) begin
					seq_nxt  = SEQ_HOLD;
					tmr_load = 1'b1;
				end else if (phy_operational) begin
					seq_nxt = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (int_phy_off) begin
					seq_nxt = SEQ_OFF;
				end else if (req_set) begin
					seq_nxt  = SEQ_HOLD;
					tmr_load = 1'b1;
				end
			end
			default: begin
				seq_nxt = SEQ_OFF;
			end
		endcase
	end

	hold_timer u_hold_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_expired)
	);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			seq_r <= SEQ_OFF;
		end else begin
			seq_r <= seq_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phy_reset_request_n_r <= 1'b0;
		end else begin
			phy_reset_request_n_r <= !in_reset(seq_nxt);
		end
	end

	// A request made while powered down completes at the next release
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			req_r <= 1'b0;
		end else if (req_set) begin
			req_r <= 1'b1;
		end else if (release_now) begin
			req_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_loaded_r <= 1'b0;
		end else if (config_load_done) begin
			cfg_loaded_r <= 1'b1;
		end
	end

	// External PHY is never powered down, so ready survives state changes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ready_r <= 1'b0;
		end else if (req_set) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= (seq_nxt == SEQ_RUN) && (!ext_phy_sel || cfg_loaded_r || config_load_done);
		end
	end

	// Resume clearing overrides a software write in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lan_en_r     <= WAKE_EN_RST;
			phy_irq_en_r <= WAKE_EN_RST;
		end else if (remote_resume && res_clr_en_r) begin
			lan_en_r     <= 1'b0;
			phy_irq_en_r <= 1'b0;
		end else if (ctrl_wr) begin
			lan_en_r     <= reg_req.wdata[LAN_EN_BIT];
			phy_irq_en_r <= reg_req.wdata[PHY_IRQ_EN_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			res_clr_en_r  <= RES_CLR_EN_RST;
			res_clr_sts_r <= RES_CLR_STS_RST;
		end else if (ctrl_wr) begin
			res_clr_en_r  <= reg_req.wdata[RES_CLR_EN_BIT];
			res_clr_sts_r <= reg_req.wdata[RES_CLR_STS_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			skip_ref_r <= SKIP_REF_RST;
		end else if (cfg_wr) begin
			skip_ref_r <= reg_req.wdata[SKIP_REF_BIT];
		end
	end

	// Arming comes from the detection logic, not from the wake enables
	always_comb begin
		sts_set          = STS_RST;
		sts_set[STS_PHY] = wake_evt.phy_wake && wake_evt.phy_armed;
		sts_set[STS_LAN] = wake_evt.lan_wake && wake_evt.lan_armed;
		sts_set[STS_EEE] = (wake_evt.energy_eff_rx_wake && ((pm_state == PM_LP0) || (pm_state == PM_LP3)))
			|| (wake_evt.energy_eff_tx_wake && (pm_state == PM_LP3));
	end

	always_comb begin
		sts_clr          = STS_RST;
		sts_clr[STS_PHY] = ctrl_wr && reg_req.wdata[WCS_PHY_BIT];
		sts_clr[STS_LAN] = (ctrl_wr && reg_req.wdata[WCS_LAN_BIT]) || (remote_resume && res_clr_sts_r);
		sts_clr[STS_EEE] = (ctrl_wr && reg_req.wdata[EEE_STS_BIT]) || (remote_resume && res_clr_sts_r);
	end

	// Bits are independent, so any mix of causes can be held at once
	sticky_status #(
		.W (STS_W)
	) u_wake_status (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.set      (sts_set),
		.clr      (sts_clr),
		.sts      (sts)
	);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (reg_req.rd && reg_hit(reg_req.addr, PM_CTRL_OFS)) begin
			rdata_r                  <= '0;
			rdata_r[WCS_PHY_BIT]     <= sts[STS_PHY];
			rdata_r[WCS_LAN_BIT]     <= sts[STS_LAN];
			rdata_r[PHY_IRQ_EN_BIT]  <= phy_irq_en_r;
			rdata_r[LAN_EN_BIT]      <= lan_en_r;
			rdata_r[PHY_RESET_REQUEST_BIT]     <= req_r;
			rdata_r[READY_BIT]       <= ready_r;
			rdata_r[RES_CLR_EN_BIT]  <= res_clr_en_r;
			rdata_r[RES_CLR_STS_BIT] <= res_clr_sts_r;
			rdata_r[EEE_STS_BIT]     <= sts[STS_EEE];
		end else if (reg_req.rd && reg_hit(reg_req.addr, PM_CFG_OFS)) begin
			rdata_r               <= '0;
			rdata_r[SKIP_REF_BIT] <= skip_ref_r;
		end else begin
			rdata_r <= '0;
		end
	end

	assign reg_rdata           = rdata_r;
	assign phy_reset_n         = phy_reset_request_n_r;
	assign device_ready        = ready_r;
	assign lan_wake_enable     = lan_en_r;
	assign phy_irq_wake_enable = phy_irq_en_r;

endmodule : phy_reset_wake_status_ctrl

// >>> design/pm_ctrl_pkg.sv
// Constants, field layout and carrier types for the PHY reset and wake status control block.
// Assumes a single 25 MHz core clock and a synchronous active-low reset.
package pm_ctrl_pkg;

	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned PHY_RESET_REQUEST_MIN_MS = 4;
	localparam int unsigned ANA_REF_MAX_MS = 128;
	localparam int unsigned MIN_HOLD_CYC   = PHY_RESET_REQUEST_MIN_MS * (CLK_HZ / 1000);
	localparam int unsigned REF_MAX_CYC    = ANA_REF_MAX_MS * (CLK_HZ / 1000);
	localparam int          TMR_W          = 22;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] PM_CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] PM_CFG_OFS  = 8'h04;

	localparam int WCS_PHY_BIT     = 0;
	localparam int WCS_LAN_BIT     = 1;
	localparam int PHY_IRQ_EN_BIT  = 2;
	localparam int LAN_EN_BIT      = 3;
	localparam int PHY_RESET_REQUEST_BIT     = 4;
	localparam int READY_BIT       = 7;
	localparam int RES_CLR_EN_BIT  = 8;
	localparam int RES_CLR_STS_BIT = 9;
	localparam int EEE_STS_BIT     = 12;
	localparam int SKIP_REF_BIT    = 0;

	localparam logic RES_CLR_EN_RST  = 1'b1;
	localparam logic RES_CLR_STS_RST = 1'b0;
	localparam logic WAKE_EN_RST     = 1'b0;
	localparam logic SKIP_REF_RST    = 1'b0;

	localparam int STS_W   = 3;
	localparam int STS_PHY = 0;
	localparam int STS_LAN = 1;
	localparam int STS_EEE = 2;
	localparam logic [STS_W-1:0] STS_RST = 3'h0;

	typedef enum logic [2:0] {
		PM_NORM_UNCFG = 3'b000,
		PM_NORM_CFG   = 3'b001,
		PM_LP0        = 3'b010,
		PM_LP1        = 3'b011,
		PM_LP2        = 3'b100,
		PM_LP3        = 3'b101
	} pm_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_s;

	typedef struct packed {
		logic phy_wake;
		logic phy_armed;
		logic lan_wake;
		logic lan_armed;
		logic energy_eff_rx_wake;
		logic energy_eff_tx_wake;
	} wake_evt_s;

	typedef struct packed {
		logic done;
		logic remote;
	} resume_s;

endpackage : pm_ctrl_pkg

// >>> design/sticky_status.sv
// Sticky status bits with separate set and clear vectors.
// Assumes set and clear arrive from the same clock; a set in the clearing cycle wins.
`timescale 1ns/1ps
module sticky_status
	import pm_ctrl_pkg::*;
#(
	parameter int W = STS_W
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] sts
);
	logic [W-1:0] sts_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sts_r <= '0;
		end else begin
			sts_r <= (sts_r & ~clr) | set;
		end
	end

	assign sts = sts_r;

endmodule : sticky_status

// >>> test/phy_model.sv
// Behavioural PHY: reference settling and operational status against its reset.
// Assumes an active-low reset from the block; ref_slow keeps the reference unsettled.
`timescale 1ns/1ps
module phy_model #(
	parameter int REF_DLY = 12,
	parameter int OP_DLY  = 3
) (
	input  wire logic core_clk,
	input  wire logic phy_reset_n,
	input  wire logic ref_slow,
	output logic      ana_ref_stable,
	output logic      phy_operational
);
	int low_r;
	int high_r;
	// Every new reset restarts the PHY: operational drops when reset is entered, reference settling drops at release
	always_ff @(posedge core_clk) begin
		low_r <= phy_reset_n ? 0 : low_r + 1;
		high_r <= phy_reset_n ? high_r + 1 : 0;
	end
	assign ana_ref_stable  = !ref_slow && low_r >= REF_DLY;
	assign phy_operational = high_r >= OP_DLY;
endmodule : phy_model

// >>> test/phy_reset_wake_status_ctrl_tb.sv
// Self-checking bench for the PHY reset and wake status block.
// Assumes the small hold counts below and the behavioural PHY beside it.
`timescale 1ns/1ps
module phy_reset_wake_status_ctrl_tb;
	import pm_ctrl_pkg::*;
	logic        core_clk, rst_n, ext_phy_sel, config_load_done, ref_slow;
	logic        ana_ref_stable, phy_operational, phy_reset_n, device_ready;
	logic        lan_wake_enable, phy_irq_wake_enable;
	reg_req_s    reg_req;
	logic [31:0] reg_rdata;
	pm_state_e   pm_state;
	wake_evt_s   wake_evt;
	resume_s     resume;
	int          fails, n_compared, cyc;
	localparam logic [7:0] CT = PM_CTRL_OFS;

	phy_reset_wake_status_ctrl #(.MIN_HOLD_P(8), .REF_MAX_P(20)) phy_reset_wake_status_ctrl_i (
		.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.pm_state(pm_state), .ext_phy_sel(ext_phy_sel), .config_load_done(config_load_done),
		.ana_ref_stable(ana_ref_stable), .phy_operational(phy_operational), .wake_evt(wake_evt),
		.resume(resume), .phy_reset_n(phy_reset_n), .device_ready(device_ready),
		.lan_wake_enable(lan_wake_enable), .phy_irq_wake_enable(phy_irq_wake_enable));
	phy_model phy_model_i (.core_clk(core_clk), .phy_reset_n(phy_reset_n), .ref_slow(ref_slow),
		.ana_ref_stable(ana_ref_stable), .phy_operational(phy_operational));

	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_sim;
		end
	end

	task end_sim;
		$display("fails %0d n_compared %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task tk(int n);
		repeat (n) @(posedge core_clk);
	endtask : tk
	task ck(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : ck
	task wr(logic [7:0] a, logic [31:0] d);
		reg_req <= {a, d, 2'b10};
		tk(1);
		reg_req <= '0;
		tk(1);
	endtask : wr
	// Data stands only in the cycle after the strobe, so it is looked at there
	task rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, string nm);
		reg_req <= {a, 32'h0, 2'b01};
		tk(1);
		reg_req <= '0;
		#1 ck(nm, e, reg_rdata & m);
		tk(1);
	endtask : rd
	task ev(logic [5:0] e);
		wake_evt <= e;
		tk(1);
		wake_evt <= '0;
	endtask : ev
	task wready;
		for (int i = 0; i < 300 && device_ready !== 1'b1; i++) @(negedge core_clk);
		ck("ready", 1, device_ready);
		tk(1);
	endtask : wready
	// Counts reset-low cycles from the request edge, sampled mid-cycle
	task hold(int lo, int hi, int n);
		@(negedge core_clk);
		while (!phy_reset_n && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		n_compared++;
		if (n < lo || n > hi) begin
			fails++;
			$display("CHECK FAILED hold exp %0d..%0d got %0d", lo, hi, n);
		end
		tk(1);
	endtask : hold

	task t_regs;
		wready;
		rd(CT, 32'hffffffff, 32'h180, "ctrl");
		rd(PM_CFG_OFS, 32'hffffffff, 0, "cfg");
		rd(8'h08, 32'hffffffff, 0, "unmapped");
	endtask : t_regs
	task t_hold;
		wr(PM_CFG_OFS, 1);
		wr(CT, 32'h110);
		wr(CT, 32'h110);
		hold(8, 10, 3);
		rd(CT, 32'h10, 0, "request");
		wready;
	endtask : t_hold
	task t_ref;
		wr(PM_CFG_OFS, 0);
		wr(CT, 32'h110);
		hold(12, 16, 1);
		wready;
		ref_slow <= 1;
		wr(CT, 32'h110);
		hold(20, 22, 1);
		ref_slow <= 0;
		wready;
	endtask : t_ref
	task t_wake;
		ev(6'b111000);
		rd(CT, 3, 1, "cause");
		ev(6'b001100);
		rd(CT, 3, 3, "cause");
		wr(CT, 32'h101);
		rd(CT, 3, 2, "clear");
		pm_state <= PM_LP0;
		ev(6'b000001);
		rd(CT, 32'h1000, 0, "eee");
		ev(6'b000010);
		rd(CT, 32'h1000, 32'h1000, "eee");
		wr(CT, 32'h1102);
		pm_state <= PM_LP3;
		ev(6'b000001);
		rd(CT, 32'h1000, 32'h1000, "eee");
		pm_state <= PM_NORM_CFG;
	endtask : t_wake
	task t_resume;
		wr(CT, 32'h130c);
		ev(6'b111100);
		resume <= 2'b10;
		tk(1);
		resume <= '0;
		#1 ck("en", 3, {lan_wake_enable, phy_irq_wake_enable});
		rd(CT, 32'h1003, 32'h0003, "cause");
		resume <= 2'b11;
		tk(1);
		resume <= '0;
		#1 ck("en", 0, {lan_wake_enable, phy_irq_wake_enable});
		rd(CT, 32'h1003, 1, "cause");
	endtask : t_resume
	task t_states;
		pm_state <= PM_LP2;
		tk(3);
		#1 ck("off", 0, {phy_reset_n, device_ready});
		pm_state <= PM_NORM_CFG;
		wready;
		wr(CT, 32'h110);
		wready;
		pm_state <= PM_NORM_UNCFG;
		tk(3);
		#1 ck("off", 0, {phy_reset_n, device_ready});
		pm_state <= PM_NORM_CFG;
		wready;
		ext_phy_sel <= 1;
		wr(CT, 32'h110);
		wready;
		pm_state <= PM_LP2;
		tk(4);
		pm_state <= PM_NORM_UNCFG;
		tk(4);
		pm_state <= PM_NORM_CFG;
		#1 ck("ext", 1, device_ready);
	endtask : t_states

	initial begin
		rst_n = 0;
		reg_req = '0;
		pm_state = PM_NORM_CFG;
		ext_phy_sel = 0;
		config_load_done = 1;
		ref_slow = 0;
		wake_evt = '0;
		resume = '0;
		tk(20);
		rst_n <= 1;
		t_regs;
		t_hold;
		t_ref;
		t_wake;
		t_resume;
		t_states;
		end_sim;
	end
endmodule : phy_reset_wake_status_ctrl_tb

// >>> test/pm_ctrl_props.sv
// Checker on the ports of the PHY reset and wake status block.
// Assumes the one core clock and its synchronous active-low reset.
`timescale 1ns/1ps
module pm_ctrl_props
	import pm_ctrl_pkg::*;
#(
	parameter int unsigned MIN_HOLD_P = 8
) (
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire reg_req_s          reg_req,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire pm_state_e         pm_state,
	input wire logic              ext_phy_sel,
	input wire logic              phy_operational,
	input wire wake_evt_s         wake_evt,
	input wire resume_s           resume,
	input wire logic              phy_reset_n,
	input wire logic              device_ready,
	input wire logic              lan_wake_enable,
	input wire logic              phy_irq_wake_enable
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] low_cnt_r;
	logic       clr_en_r;
	wire        ctl_wr = reg_req.wr && reg_req.addr == PM_CTRL_OFS;
	// Saturates so a long off period cannot wrap into a short count
	always_ff @(posedge core_clk) begin
		if (!rst_n || phy_reset_n)
			low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hff)
			low_cnt_r <= low_cnt_r + 8'h01;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			clr_en_r <= 1'b1;
		else if (ctl_wr)
			clr_en_r <= reg_req.wdata[RES_CLR_EN_BIT];
	end
	sequence s_rd_ctl;
		reg_req.rd && reg_req.addr == PM_CTRL_OFS;
	endsequence
	sequence s_int_off;
		!ext_phy_sel && (pm_state == PM_NORM_UNCFG || pm_state == PM_LP2);
	endsequence
	AST_HOLD_MIN: assert property ($rose(phy_reset_n) |-> low_cnt_r >= MIN_HOLD_P)
		else $error("PHY reset released early");
	AST_READY_IN_RST: assert property (!phy_reset_n |-> !device_ready)
		else $error("ready while PHY in reset");
	AST_REQ_DROP: assert property (ctl_wr && reg_req.wdata[PHY_RESET_REQUEST_BIT] |=> !device_ready && !phy_reset_n)
		else $error("reset request did not act");
	AST_READY_RISE: assert property ($rose(device_ready) |-> phy_reset_n && $past(phy_operational))
		else $error("ready before PHY operational");
	AST_INT_OFF: assert property (s_int_off [*2] |-> !phy_reset_n)
		else $error("internal PHY not held off");
	AST_PHY_STS: assert property ((wake_evt.phy_wake && wake_evt.phy_armed) ##1 s_rd_ctl |=> reg_rdata[WCS_PHY_BIT])
		else $error("phy wake cause not set");
	AST_LAN_STS: assert property ((wake_evt.lan_wake && wake_evt.lan_armed) ##1 s_rd_ctl |=> reg_rdata[WCS_LAN_BIT])
		else $error("lan wake cause not set");
	AST_EEE_STS: assert property ((wake_evt.energy_eff_tx_wake && pm_state == PM_LP3) ##1 s_rd_ctl |=> reg_rdata[EEE_STS_BIT])
		else $error("eee wake cause not set");
	AST_HOST_RES: assert property (resume.done && !resume.remote && !reg_req.wr |=> $stable(lan_wake_enable) && $stable(phy_irq_wake_enable))
		else $error("host resume changed enables");
	AST_RES_CLR: assert property (resume.done && resume.remote && clr_en_r |=> !lan_wake_enable && !phy_irq_wake_enable)
		else $error("remote resume kept enables");
	AST_EN_WR: assert property (ctl_wr && !resume.done |=> lan_wake_enable == $past(reg_req.wdata[LAN_EN_BIT]) && phy_irq_wake_enable == $past(reg_req.wdata[PHY_IRQ_EN_BIT]))
		else $error("enable write lost");
endmodule : pm_ctrl_props

bind phy_reset_wake_status_ctrl pm_ctrl_props #(.MIN_HOLD_P(MIN_HOLD_P)) pm_ctrl_props_i (
	.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .pm_state(pm_state),
	.ext_phy_sel(ext_phy_sel), .phy_operational(phy_operational), .wake_evt(wake_evt), .resume(resume),
	.phy_reset_n(phy_reset_n), .device_ready(device_ready), .lan_wake_enable(lan_wake_enable),
	.phy_irq_wake_enable(phy_irq_wake_enable)
);
